// ==== hdl/mtm_modulo_timer.v ====
// 8-bit modulo timer with prescaler and clock source selection, AHB-Lite slave.
// Assumes one 20 MHz bus clock; pin and fixed clock arrive asynchronously.
// Overview of operation
// [R1] Counter rolling from modulo value to zero sets the overflow flag; software cannot set it.
// [R2] Flag clears on write 0 only after a read that saw it set.
// [R3] Interrupt request is flag AND enable bit 6; reset clears the enable.
// [R4] Software clears the flag before setting the interrupt enable.
// [R5] Writing 1 to bit 5 zeroes counter and flag; reads back zero.
// [R6] Halt bit 4 freezes the counter; clearing it resumes from held value.
// [R7] Reset sets the halt bit.
// [R8] Unused status bits 3:0 and config bits 7:6 read zero.
// [R9] Source select 5:4 picks bus, fixed clock, pin falling or pin rising edges.
// [R10] Changing source does not clear the counter.
// [R11] Reset selects the bus clock source.
// [R12] Prescale field divides the source by two to the field value, up to 256.
// [R13] Prescale codes above eight divide by 256.
// [R14] Changing prescale does not clear the counter.
// [R15] Reset sets prescale to divide by one.
// [R16] Count register is read-only current count, reset to zero.
// [R17] Modulo zero makes the counter free-running over the full range.
// [R18] Any modulo write zeroes counter and flag and stores the value.
// [R19] Reset sets the modulo to zero.
// [R20] Counter increments per tick to the modulo, then wraps to zero.
// [R21] Overflow between read and clear-write disarms the sequence; flag stays.
// [R22] Pin clock is synchronised; it must run at most quarter bus rate.
// [R23] Debug mode suspends counting; it resumes from the held value.
// [R24] Free-running counter wraps 0xff to zero and sets the flag.
// [R25] Pin and fixed clock edges become one-cycle enables into the prescaler.
`timescale 1ns/1ns
`include "mtm_defines.vh"

module mtm_modulo_timer
(
  input  wire        core_clk,
  input  wire        rst,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        ext_timer_clock_pin,
  input  wire        fixed_freq_clock,
  input  wire        debug_active,
  output wire        timer_irq
);

  // Control and status registers
  reg        overflow_flag_r;
  reg        overflow_nxt;
  reg        overflow_irq_enable_r;
  reg        counter_halt_r;
  reg  [1:0] source_select_r;
  reg  [3:0] prescale_select_r;
  reg  [7:0] modulo_value_r;
  reg        clear_armed_r;
  reg        clear_armed_nxt;

  // Counter and prescaler
  reg  [7:0] count_r;
  reg  [7:0] count_nxt;
  reg  [7:0] presc_r;
  wire [8:0] count_sum;
  wire [8:0] presc_sum;
  wire [8:0] presc_match;
  wire [3:0] ps_eff;
  reg        src_tick;
  reg        presc_tick;
  wire       run;
  wire       counter_reset;
  wire       overflow_evt;
  wire       at_limit;

  // Synchronisers and edge enables
  reg        pin_s1_r;
  reg        pin_s2_r;
  reg        pin_s3_r;
  reg        fix_s1_r;
  reg        fix_s2_r;
  reg        fix_s3_r;
  reg        dbg_s1_r;
  reg        dbg_s2_r;
  wire       pin_rise;
  wire       pin_fall;
  wire       fix_rise;

  // Bus data phase
  reg        dph_wr_r;
  reg        dph_rd_r;
  reg  [3:0] dph_ofs_r;
  reg  [7:0] rd_byte_nxt;
  wire       addr_take;
  wire       rd_take;
  wire       wr_status;
  wire       wr_clock;
  wire       wr_modulo;
  wire       rd_status;
  wire [7:0] status_view;
  wire [7:0] config_view;
  genvar     gi;

  // Bus slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_take = hsel & hready & htrans[1];
  assign rd_take   = addr_take & ~hwrite;

  // Data phase write flag
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      dph_wr_r <= 1'b0;
    else
      dph_wr_r <= addr_take & hwrite;
  end

  // Data phase read flag
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      dph_rd_r <= 1'b0;
    else
      dph_rd_r <= rd_take;
  end

  // Offset of the transfer in its data phase
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      dph_ofs_r <= 4'h0;
    else if (addr_take)
      dph_ofs_r <= haddr[3:0];
  end

  assign wr_status = dph_wr_r & (dph_ofs_r == `MTM_OFS_STATUS_CONTROL);
  assign wr_clock  = dph_wr_r & (dph_ofs_r == `MTM_OFS_CLOCK_CONFIG);
  assign wr_modulo = dph_wr_r & (dph_ofs_r == `MTM_OFS_MODULO_LIMIT);
  assign rd_status = dph_rd_r & (dph_ofs_r == `MTM_OFS_STATUS_CONTROL);

  // Readback views; the clear bit and unused bits read zero
  assign status_view = {overflow_flag_r, overflow_irq_enable_r, 1'b0, counter_halt_r, 4'h0}; // R5 R8
  assign config_view = {2'b00, source_select_r, prescale_select_r}; // R8

  // Read byte selected at the address phase
  always @*
  begin
    case (haddr[3:0])
      `MTM_OFS_STATUS_CONTROL: rd_byte_nxt = status_view;
      `MTM_OFS_CLOCK_CONFIG:   rd_byte_nxt = config_view;
      `MTM_OFS_COUNT_VALUE:    rd_byte_nxt = count_nxt; // R16
      `MTM_OFS_MODULO_LIMIT:   rd_byte_nxt = modulo_value_r;
      default:                 rd_byte_nxt = 8'h00;
    endcase
  end

  // Read data registered at the address phase, so it stands in the data phase
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      hrdata <= 32'h00000000;
    else if (rd_take)
      hrdata <= {24'h000000, rd_byte_nxt};
  end

  // Pin clock synchroniser; the third stage only feeds the edge detector
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_s3_r <= 1'b0;
    end
    else
    begin
      pin_s1_r <= ext_timer_clock_pin; // R22
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // Fixed clock synchroniser; the third stage only feeds the edge detector
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      fix_s1_r <= 1'b0;
      fix_s2_r <= 1'b0;
      fix_s3_r <= 1'b0;
    end
    else
    begin
      fix_s1_r <= fixed_freq_clock;
      fix_s2_r <= fix_s1_r;
      fix_s3_r <= fix_s2_r;
    end
  end

  // Debug level synchroniser
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      dbg_s1_r <= 1'b0;
      dbg_s2_r <= 1'b0;
    end
    else
    begin
      dbg_s1_r <= debug_active;
      dbg_s2_r <= dbg_s1_r;
    end
  end

  // Source edge enables
  assign pin_rise = pin_s2_r & ~pin_s3_r; // R25
  assign pin_fall = ~pin_s2_r & pin_s3_r; // R25
  assign fix_rise = fix_s2_r & ~fix_s3_r; // R25

  always @*
  begin
    case (source_select_r) // R9
      `MTM_SRC_BUS:      src_tick = 1'b1;
      `MTM_SRC_FIXED:    src_tick = fix_rise;
      `MTM_SRC_PIN_FALL: src_tick = pin_fall;
      `MTM_SRC_PIN_RISE: src_tick = pin_rise;
      default:           src_tick = 1'b1;
    endcase
  end

  assign run       = ~counter_halt_r & ~dbg_s2_r; // R6 R23
  assign presc_sum = {1'b0, presc_r} + 9'h001;
  assign count_sum = {1'b0, count_r} + 9'h001;

  // Match bit k: the low k prescaler bits are all ones
  assign presc_match[0] = 1'b1;

  generate
    for (gi = 1; gi < 9; gi = gi + 1)
    begin : g_presc_match
      assign presc_match[gi] = &presc_r[gi-1:0]; // R12
    end
  endgenerate

  // Codes above eight behave as the longest ratio
  assign ps_eff = (prescale_select_r > `MTM_PS_MAX) ? `MTM_PS_MAX : prescale_select_r; // R13

  always @*
  begin
    presc_tick = src_tick & presc_match[ps_eff]; // R12
  end

  assign counter_reset = (wr_status & hwdata[`MTM_BIT_COUNTER_CLEAR]) | wr_modulo; // R5 R18

  // Limit is the modulo value, or the top of the range when the modulo is zero
  assign at_limit     = (modulo_value_r == 8'h00) ? (count_r == 8'hff) :
                        (count_r == modulo_value_r); // R17 R24
  assign overflow_evt = run & presc_tick & ~counter_reset & at_limit; // R1

  always @*
  begin
    count_nxt = count_r;
    if (counter_reset)
      count_nxt = 8'h00; // R5 R18
    else if (run & presc_tick)
    begin
      if (overflow_evt)
        count_nxt = 8'h00; // R20
      else
        count_nxt = count_sum[7:0]; // R20
    end
  end

  // Counter
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      count_r <= `MTM_RST_COUNT; // R16
    else
      count_r <= count_nxt;
  end

  // Overflow flag: a set wins over a clear in the same cycle
  always @*
  begin
    overflow_nxt = overflow_flag_r;
    if (counter_reset)
      overflow_nxt = 1'b0; // R5 R18
    else if (wr_status & ~hwdata[`MTM_BIT_OVERFLOW_FLAG] & clear_armed_r)
      overflow_nxt = 1'b0; // R2
    if (overflow_evt)
      overflow_nxt = 1'b1; // R1 R21
  end

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      overflow_flag_r <= 1'b0;
    else
      overflow_flag_r <= overflow_nxt;
  end

  // Clear sequence: a status read that sees the flag arms, a new overflow disarms
  always @*
  begin
    clear_armed_nxt = clear_armed_r;
    if (overflow_evt | wr_status | counter_reset)
      clear_armed_nxt = 1'b0; // R21
    else if (rd_status & hrdata[`MTM_BIT_OVERFLOW_FLAG])
      clear_armed_nxt = 1'b1; // R2
  end

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      clear_armed_r <= 1'b0;
    else
      clear_armed_r <= clear_armed_nxt;
  end

  // Prescaler restarts with the counter
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      presc_r <= 8'h00;
    else if (counter_reset)
      presc_r <= 8'h00;
    else if (run & src_tick)
      presc_r <= presc_sum[7:0];
  end

  // Interrupt enable
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      overflow_irq_enable_r <= `MTM_RST_IRQ_ENABLE; // R3
    else if (wr_status)
      overflow_irq_enable_r <= hwdata[`MTM_BIT_IRQ_ENABLE]; // R3
  end

  // Halt
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      counter_halt_r <= `MTM_RST_HALT; // R7
    else if (wr_status)
      counter_halt_r <= hwdata[`MTM_BIT_COUNTER_HALT]; // R6
  end

  // Source select
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      source_select_r <= `MTM_RST_SOURCE; // R11
    else if (wr_clock)
      source_select_r <= hwdata[`MTM_SRC_HI:`MTM_SRC_LO]; // R10
  end

  // Prescale select
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      prescale_select_r <= `MTM_RST_PRESCALE; // R15
    else if (wr_clock)
      prescale_select_r <= hwdata[`MTM_PS_HI:`MTM_PS_LO]; // R14
  end

  // Modulo value
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      modulo_value_r <= `MTM_RST_MODULO; // R19
    else if (wr_modulo)
      modulo_value_r <= hwdata[7:0]; // R18
  end

  assign timer_irq = overflow_flag_r & overflow_irq_enable_r; // R3

endmodule

// ==== hdl/mtm_defines.vh ====
// Constants for the modulo timer: register offsets, field positions, resets.
// Assumes a 32-bit AHB-Lite register bus, one aligned word per register.
`ifndef MTM_DEFINES_VH
`define MTM_DEFINES_VH

`define MTM_OFS_STATUS_CONTROL 4'h0
`define MTM_OFS_CLOCK_CONFIG   4'h4
`define MTM_OFS_COUNT_VALUE    4'h8
`define MTM_OFS_MODULO_LIMIT   4'hc

`define MTM_BIT_OVERFLOW_FLAG  7
`define MTM_BIT_IRQ_ENABLE     6
`define MTM_BIT_COUNTER_CLEAR  5
`define MTM_BIT_COUNTER_HALT   4
`define MTM_SRC_HI             5
`define MTM_SRC_LO             4
`define MTM_PS_HI              3
`define MTM_PS_LO              0

`define MTM_SRC_BUS            2'h0
`define MTM_SRC_FIXED          2'h1
`define MTM_SRC_PIN_FALL       2'h2
`define MTM_SRC_PIN_RISE       2'h3

`define MTM_PS_MAX             4'h8

`define MTM_RST_HALT           1'b1
`define MTM_RST_IRQ_ENABLE     1'b0
`define MTM_RST_SOURCE         2'h0
`define MTM_RST_PRESCALE       4'h0
`define MTM_RST_MODULO         8'h00
`define MTM_RST_COUNT          8'h00

`endif

// ==== sim/mtm_checker_sva.sv ====
// Checker for the modulo timer: bus answer, readback fields and interrupt.
// Sees only the top ports; bound to every timer instance.
`timescale 1ns/1ns
module mtm_checker (
  input logic        core_clk,
  input logic        rst,
  input logic        hsel,
  input logic [31:0] haddr,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic [31:0] hwdata,
  input logic        hready,
  input logic [31:0] hrdata,
  input logic        hreadyout,
  input logic        hresp,
  input logic        timer_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic       v_r, w_r, ie_r, hl_r;
  logic [3:0] a_r;
  logic [7:0] md_r, cf_r;
  wire        rd = v_r & ~w_r;
  always @(posedge core_clk or posedge rst)
    if (rst)
    begin
      {v_r, w_r, ie_r, hl_r, a_r} <= 8'h10;
      md_r <= 8'h00;
      cf_r <= 8'h00;
    end
    else
    begin
      v_r <= hsel & hready & htrans[1];
      w_r <= hwrite;
      a_r <= haddr[3:0];
      if (v_r && w_r && a_r == 4'h0) {ie_r, hl_r} <= {hwdata[6], hwdata[4]};
      if (v_r && w_r && a_r == 4'h4) cf_r <= {2'h0, hwdata[5:0]};
      if (v_r && w_r && a_r == 4'hc) md_r <= hwdata[7:0];
    end
  property p_rdy; hreadyout && !hresp; endproperty
  property p_up; rd |-> hrdata[31:8] == 24'h0; endproperty
  property p_st; rd && a_r == 4'h0 |-> hrdata[6:0] == {ie_r, 1'b0, hl_r, 4'h0}; endproperty
  property p_cf; rd && a_r == 4'h4 |-> hrdata[7:0] == cf_r; endproperty
  property p_md; rd && a_r == 4'hc |-> hrdata[7:0] == md_r; endproperty
  property p_cnt; rd && a_r == 4'h8 && md_r != 8'h00 |-> hrdata[7:0] <= md_r; endproperty
  property p_irq; !ie_r |-> !timer_irq; endproperty
  property p_ien; v_r && w_r && a_r == 4'h0 && !hwdata[6] |=> !timer_irq [*2]; endproperty
  a_rdy: assert property (p_rdy) else $error("bus answer wrong");
  a_up: assert property (p_up) else $error("upper read bits set");
  a_st: assert property (p_st) else $error("status readback wrong");
  a_cf: assert property (p_cf) else $error("config readback wrong");
  a_md: assert property (p_md) else $error("modulo readback wrong");
  a_cnt: assert property (p_cnt) else $error("count above modulo");
  a_irq: assert property (p_irq) else $error("irq while disabled");
  a_ien: assert property (p_ien) else $error("irq after disable");
  c_flag: cover property (rd && a_r == 4'h0 && hrdata[7]);
  c_irq: cover property (timer_irq);
  c_wrap: cover property (rd && a_r == 4'h8 && md_r == 8'h00);
endmodule
bind mtm_modulo_timer mtm_checker u_chk (.core_clk(core_clk), .rst(rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .timer_irq(timer_irq));

// ==== sim/mtm_modulo_timer_tb_top.sv ====
// Self-checking bench for the modulo timer over AHB-Lite.
// Drives bus, pin, fixed clock and debug inputs at a 50 ns core_clk.
`timescale 1ns/1ns
module mtm_modulo_timer_tb_top;
  logic        core_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic        ext_timer_clock_pin = 1'b0, fixed_freq_clock = 1'b0, debug_active = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic        hrdy, hresp, timer_irq;
  logic [7:0]  m;
  int          num_errors = 0, num_checks = 0, tick = 0, p, n;
  mtm_modulo_timer dut (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
    .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp), .ext_timer_clock_pin(ext_timer_clock_pin),
    .fixed_freq_clock(fixed_freq_clock), .debug_active(debug_active), .timer_irq(timer_irq));
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    tick <= tick + 1;
    fixed_freq_clock <= tick[2];
    ext_timer_clock_pin <= (tick % 12) < 6;
    if (tick == 40000)
    begin
      num_errors++;
      summarize;
    end
  end
  task summarize;
    if (num_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  function logic [7:0] ex(int p, int n);
    return 8'((n + 2) >> (p > 8 ? 8 : p));
  endfunction
  task chk(input string s, input logic [7:0] e, input logic [7:0] g, input int t);
    logic [7:0] df;
    df = g - e;
    num_checks++;
    if ($isunknown(g) || (df > t && df < 256 - t))
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {28'h0, a};
    @(posedge core_clk);
    while (hrdy !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hrdy !== 1'b1) @(posedge core_clk);
    q = hrdata;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h0, d});
  endtask
  task rc(input string s, input logic [3:0] a, input logic [7:0] e, input int t);
    xfer(1'b0, a, 32'h0);
    chk(s, e, q[7:0], t);
  endtask
  task run(input logic [7:0] cf, input int n, input logic [7:0] e, input int t);
    wr(4'hc, 8'h00);
    wr(4'h4, cf);
    wr(4'h0, 8'h00);
    repeat (n) @(posedge core_clk);
    wr(4'h0, 8'h10);
    rc("count", 4'h8, e, t);
    wr(4'h4, ~cf & 8'h3f);
    rc("count", 4'h8, e, t);
  endtask
  initial
  begin
    void'($urandom(32'h8f77));
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    rc("status", 4'h0, 8'h10, 0);
    rc("config", 4'h4, 8'h00, 0);
    rc("modulo", 4'hc, 8'h00, 0);
    wr(4'h8, 8'hff);
    rc("count", 4'h8, 8'h00, 0);
    m = 8'h02 + 8'($urandom % 30);
    wr(4'hc, m);
    wr(4'h0, 8'h00);
    repeat (m + 5) @(posedge core_clk);
    wr(4'h0, 8'h10);
    rc("status", 4'h0, 8'h90, 0);
    wr(4'h0, 8'h10);
    rc("status", 4'h0, 8'h10, 0);
    wr(4'h0, 8'h00);
    repeat (m + 5) @(posedge core_clk);
    wr(4'h0, 8'h30);
    rc("status", 4'h0, 8'h10, 0);
    rc("count", 4'h8, 8'h00, 0);
    wr(4'h0, 8'h00);
    repeat (m + 5) @(posedge core_clk);
    wr(4'h0, 8'h10);
    wr(4'hc, m + 8'h01);
    rc("status", 4'h0, 8'h10, 0);
    rc("count", 4'h8, 8'h00, 0);
    wr(4'h0, 8'h40);
    repeat (m + 8) @(posedge core_clk);
    chk("irq", 8'h01, {7'h0, timer_irq}, 0);
    wr(4'h0, 8'h50);
    rc("status", 4'h0, 8'hd0, 0);
    wr(4'h0, 8'h50);
    @(posedge core_clk);
    chk("irq", 8'h00, {7'h0, timer_irq}, 0);
    debug_active <= 1'b1;
    wr(4'hc, 8'h00);
    wr(4'h0, 8'h00);
    repeat (40) @(posedge core_clk);
    wr(4'h0, 8'h10);
    debug_active <= 1'b0;
    rc("count", 4'h8, 8'h00, 0);
    for (p = 0; p < 16; p++) run(8'(p), 1000, ex(p, 1000), 2);
    run(8'h00, 300, ex(0, 300), 2);
    rc("status", 4'h0, 8'h90, 0);
    for (p = 1; p < 4; p++) run(8'(p << 4), 1000, p == 1 ? 8'h7d : 8'h53, 3);
    p = $urandom % 16;
    n = 200 + $urandom % 800;
    run(8'(p), n, ex(p, n), 2);
    summarize;
  end
endmodule
